// ===== design/analog_input_diag_record.v
// read-only diagnostic record of a four-channel analog input module
// assumes error inputs come from logic on sys_clk; reads are byte-indexed
// error bytes follow live input levels, they are not sticky
`timescale 1ns/100ps
`default_nettype none
`include "diag_record_map.vh"

// How it works
// - module class 0101b in bits 3..0
// - bit 4 flags channel information present
// - bit 3 flags diagnostics buffer overflow
// - bit 4 flags internal communication error
// - channel type code 71h, bit 7 zero
// - diagnostic bits per channel reads 08h
// - channel count reads 04h
// - summary bit n for channel group n
// - error bit 0 flags configuration error
// - error bit 6 flags range underflow
// - error bit 7 flags range overflow
// - timestamp holds ticker at diagnostic event
// - ticker starts at zero from power-on
// - ticker wraps as a 32-bit count
module analog_input_diag_record #(
  parameter integer CHANNELS = 4,
  parameter integer TS_WIDTH = 32
) (
  // clock and reset
  input  wire                sys_clk,
  input  wire                rst_n,
  // error sources from measuring logic
  input  wire [CHANNELS-1:0] config_err,
  input  wire [CHANNELS-1:0] range_underflow,
  input  wire [CHANNELS-1:0] range_overflow,
  input  wire                diag_buf_overflow,
  input  wire                internal_comm_err,
  // record read port
  input  wire                rd_en,
  input  wire [7:0]          rd_index,
  output reg  [7:0]          rd_data,
  output reg                 rd_valid,
  // live state
  output reg                 diag_event,
  output wire [TS_WIDTH-1:0] us_ticks
);

  // record storage
  wire [7:0]          chan_err  [0:CHANNELS-1];
  wire [7:0]          chan_byte [0:3];
  reg                 buf_ovf_flag;
  reg                 comm_err_flag;
  reg  [TS_WIDTH-1:0] diag_timestamp;
  reg  [7:0]          ts_shadow [0:TS_WIDTH/8-1];
  reg  [7:0]          next_rd_data;

  // decode and event nets
  wire [7:0]          internal_diagnostic;
  wire [7:0]          module_information;
  wire [7:0]          channel_type;
  wire [7:0]          channel_error_summary;
  wire [CHANNELS-1:0] new_chan_err;
  wire [7:0]          next_internal;
  wire                new_internal;
  wire                raised;

  us_ticker #(
    .DIV   (`TICK_PERIOD_NS / `SYS_CLK_PERIOD_NS),
    .WIDTH (TS_WIDTH)
  ) ticker (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .ticks     (us_ticks),
    .us_strobe ()
  );

  // constant bytes
  assign module_information = {3'b000, 1'b1, `MODINFO_CLASS_ANALOG};
  assign channel_type       = {1'b0, `CHTYPE_ANALOG_IN};

  // internal diagnostic byte from two live flags
  assign next_internal = {3'b000, internal_comm_err, diag_buf_overflow, 3'b000};
  assign new_internal  = |(next_internal & ~internal_diagnostic);
  assign internal_diagnostic = {3'b000, comm_err_flag, buf_ovf_flag, 3'b000};

  // buffer overflow flag
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_ovf_flag <= 1'b0;
    end else begin
      buf_ovf_flag <= diag_buf_overflow;
    end
  end

  // communication error flag
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      comm_err_flag <= 1'b0;
    end else begin
      comm_err_flag <= internal_comm_err;
    end
  end

  // per-channel error bytes and summary
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : chan
      reg        cfg_flag;
      reg        under_flag;
      reg        over_flag;
      wire [7:0] next_err;
      assign next_err = {range_overflow[g], range_underflow[g], 5'b00000,
                         config_err[g]};
      assign chan_err[g] = {over_flag, under_flag, 5'b00000, cfg_flag};
      assign new_chan_err[g] = |(next_err & ~chan_err[g]);
      assign channel_error_summary[g] = |chan_err[g];

      // configuration error bit
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          cfg_flag <= 1'b0;
        end else begin
          cfg_flag <= config_err[g];
        end
      end

      // underflow bit
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          under_flag <= 1'b0;
        end else begin
          under_flag <= range_underflow[g];
        end
      end

      // overflow bit
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          over_flag <= 1'b0;
        end else begin
          over_flag <= range_overflow[g];
        end
      end
    end
    if (CHANNELS < 8) begin : sum_pad
      assign channel_error_summary[7:CHANNELS] = {(8-CHANNELS){1'b0}};
    end
  endgenerate

  // four-entry channel view, zero past the last channel
  generate
    for (g = 0; g < 4; g = g + 1) begin : view
      if (g < CHANNELS) begin : live
        assign chan_byte[g] = chan_err[g];
      end else begin : absent
        assign chan_byte[g] = 8'h00;
      end
    end
  endgenerate

  // any newly raised error bit is a diagnostic event
  assign raised = new_internal | (|new_chan_err);

  // event pulse alongside the byte update
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_event <= 1'b0;
    end else begin
      diag_event <= raised;
    end
  end

  // ticker value of the event cycle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_timestamp <= {TS_WIDTH{1'b0}};
    end else if (raised) begin
      diag_timestamp <= us_ticks;
    end
  end

  // read decode, one item per record byte
  always @* begin
    next_rd_data = 8'h00;
    case (rd_index)
      // leading bytes kept out of this block
      `IDX_LEAD_0: begin
        next_rd_data = 8'h00;
      end
      `IDX_LEAD_1: begin
        next_rd_data = 8'h00;
      end
      `IDX_LEAD_2: begin
        next_rd_data = 8'h00;
      end
      // fixed and live module bytes
      `IDX_MODULE_INFORMATION: begin
        next_rd_data = module_information;
      end
      `IDX_RESERVED_C: begin
        next_rd_data = 8'h00;
      end
      `IDX_INTERNAL_DIAGNOSTIC: begin
        next_rd_data = internal_diagnostic;
      end
      `IDX_CHANNEL_TYPE: begin
        next_rd_data = channel_type;
      end
      `IDX_DIAG_BITS_PER_CHAN: begin
        next_rd_data = `DIAG_BITS_PER_CHAN;
      end
      `IDX_CHANNEL_COUNT: begin
        next_rd_data = `CHANNEL_COUNT;
      end
      `IDX_CHANNEL_ERR_SUMMARY: begin
        next_rd_data = channel_error_summary;
      end
      // per-channel error bytes
      `IDX_FIRST_CHANNEL_ERROR: begin
        next_rd_data = chan_byte[0];
      end
      `IDX_SECOND_CHANNEL_ERROR: begin
        next_rd_data = chan_byte[1];
      end
      `IDX_THIRD_CHANNEL_ERROR: begin
        next_rd_data = chan_byte[2];
      end
      `IDX_FOURTH_CHANNEL_ERROR: begin
        next_rd_data = chan_byte[3];
      end
      // spare channel bytes read as zero
      `IDX_FIRST_SPARE_ERROR: begin
        next_rd_data = 8'h00;
      end
      `IDX_SECOND_SPARE_ERROR: begin
        next_rd_data = 8'h00;
      end
      `IDX_THIRD_SPARE_ERROR: begin
        next_rd_data = 8'h00;
      end
      `IDX_LAST_SPARE_ERROR: begin
        next_rd_data = 8'h00;
      end
      `IDX_TIMESTAMP_GAP: begin
        next_rd_data = 8'h00;
      end
      // timestamp, little-endian; upper bytes from the shadow
      `IDX_DIAG_TIMESTAMP: begin
        next_rd_data = diag_timestamp[7:0];
      end
      `IDX_DIAG_TIMESTAMP_1: begin
        next_rd_data = ts_shadow[1];
      end
      `IDX_DIAG_TIMESTAMP_2: begin
        next_rd_data = ts_shadow[2];
      end
      `IDX_DIAG_TIMESTAMP_3: begin
        next_rd_data = ts_shadow[3];
      end
      // everything else reads as zero
      default: begin
        next_rd_data = 8'h00;
      end
    endcase
  end

  // answer strobe one cycle after the request
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
    end
  end

  // answer byte held until the next read
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      rd_data <= next_rd_data;
    end
  end

  // low timestamp byte freezes the upper bytes
  generate
    for (g = 0; g < TS_WIDTH / 8; g = g + 1) begin : shadow
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          ts_shadow[g] <= 8'h00;
        end else if (rd_en && rd_index == `IDX_DIAG_TIMESTAMP) begin
          ts_shadow[g] <= diag_timestamp[8*g +: 8];
        end
      end
    end
  endgenerate

endmodule // analog_input_diag_record
`default_nettype wire

// ===== design/diag_record_map.vh
// diagnostic record map: byte indices, field positions, constants, timing
// assumes byte-wide reads of the record by index
`ifndef DIAG_RECORD_MAP_VH
`define DIAG_RECORD_MAP_VH

// record byte indices
`define IDX_LEAD_0               8'h00
`define IDX_LEAD_1               8'h01
`define IDX_LEAD_2               8'h02
`define IDX_MODULE_INFORMATION   8'h03
`define IDX_RESERVED_C           8'h04
`define IDX_INTERNAL_DIAGNOSTIC  8'h05
`define IDX_CHANNEL_TYPE         8'h06
`define IDX_DIAG_BITS_PER_CHAN   8'h07
`define IDX_CHANNEL_COUNT        8'h08
`define IDX_CHANNEL_ERR_SUMMARY  8'h09
`define IDX_FIRST_CHANNEL_ERROR  8'h0A
`define IDX_SECOND_CHANNEL_ERROR 8'h0B
`define IDX_THIRD_CHANNEL_ERROR  8'h0C
`define IDX_FOURTH_CHANNEL_ERROR 8'h0D
`define IDX_FIRST_SPARE_ERROR    8'h0E
`define IDX_SECOND_SPARE_ERROR   8'h0F
`define IDX_THIRD_SPARE_ERROR    8'h10
`define IDX_LAST_SPARE_ERROR     8'h11
`define IDX_TIMESTAMP_GAP        8'h12
`define IDX_DIAG_TIMESTAMP       8'h13
`define IDX_DIAG_TIMESTAMP_1     8'h14
`define IDX_DIAG_TIMESTAMP_2     8'h15
`define IDX_DIAG_TIMESTAMP_3     8'h16

// module information fields
`define MODINFO_CLASS_ANALOG     4'h5
`define MODINFO_CHAN_PRESENT_BIT 4

// internal diagnostic fields
`define INTDIAG_BUF_OVF_BIT      3
`define INTDIAG_COMM_ERR_BIT     4

// channel type codes
`define CHTYPE_DIGITAL_IN        7'h70
`define CHTYPE_ANALOG_IN         7'h71
`define CHTYPE_DIGITAL_OUT       7'h72
`define CHTYPE_ANALOG_OUT        7'h73
`define CHTYPE_ANALOG_IO         7'h74
`define CHTYPE_COUNTER           7'h76

// fixed counts
`define DIAG_BITS_PER_CHAN       8'h08
`define CHANNEL_COUNT            8'h04

// channel error byte fields
`define CHANNEL_ERROR_SUMMARY_CONFIG_BIT         0
`define CHANNEL_ERROR_SUMMARY_UNDERFLOW_BIT      6
`define CHANNEL_ERROR_SUMMARY_OVERFLOW_BIT       7

// timing
`define SYS_CLK_PERIOD_NS        20
`define TICK_PERIOD_NS           1000

`endif

// ===== design/us_ticker.v
// free-running microsecond ticker with its one-microsecond strobe
// assumes a single system clock; counts from zero after reset
`timescale 1ns/100ps
`default_nettype none
`include "diag_record_map.vh"

module us_ticker #(
  parameter integer DIV   = `TICK_PERIOD_NS / `SYS_CLK_PERIOD_NS,
  parameter integer WIDTH = 32
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             rst_n,
  // ticker value
  output reg  [WIDTH-1:0] ticks,
  output reg              us_strobe
);

  localparam integer PW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam integer  LAST_I = DIV - 1;
  localparam [PW-1:0] LAST   = LAST_I[PW-1:0];

  reg [PW-1:0] prescale;

  // one-cycle strobe every DIV system clocks
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale  <= {PW{1'b0}};
      us_strobe <= 1'b0;
    end else if (prescale == LAST) begin
      prescale  <= {PW{1'b0}};
      us_strobe <= 1'b1;
    end else begin
      prescale  <= prescale + 1'b1;
      us_strobe <= 1'b0;
    end
  end

  // natural binary wrap after all ones
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ticks <= {WIDTH{1'b0}};
    end else if (us_strobe) begin
      ticks <= ticks + 1'b1;
    end
  end

endmodule // us_ticker
`default_nettype wire

// ===== tb/diag_reader.sv
// coupler model: byte reads of the record
// assumes one request per clock
`timescale 1ns/100ps
`default_nettype none
module diag_reader (
  // read request
  input  wire             sys_clk,
  output var  logic       rd_en,
  output var  logic [7:0] rd_index
);
  initial {rd_en, rd_index} = 9'h000;
  // idle index flips, never held
  task automatic rd(input logic [7:0] i, input logic en);
    rd_en    <= en;
    rd_index <= en ? i : ~rd_index;
    @(posedge sys_clk);
  endtask
endmodule // diag_reader
`default_nettype wire

// ===== tb/diag_record_sva.sv
// checker: read timing, bytes, event, ticker
// assumes binding into the record
`timescale 1ns/100ps
`default_nettype none
module diag_record_sva (
  // watched ports
  input wire        sys_clk,
  input wire        rst_n,
  input wire [3:0]  config_err,
  input wire [3:0]  range_underflow,
  input wire [3:0]  range_overflow,
  input wire        diag_buf_overflow,
  input wire        internal_comm_err,
  input wire        rd_en,
  input wire [7:0]  rd_index,
  input wire [7:0]  rd_data,
  input wire        rd_valid,
  input wire        diag_event,
  input wire [31:0] us_ticks
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire [3:0] any_ch = config_err | range_underflow | range_overflow;
  sequence rd_at(logic [7:0] i);
    rd_en && rd_index == i;
  endsequence
  AST_RDV: assert property (rd_valid == $past(rd_en)) else $error("read timing");
  AST_MOD: assert property (rd_at(8'h03) |=> rd_data == 8'h15) else $error("modinfo");
  AST_NCH: assert property (rd_at(8'h08) |=> rd_data == 8'h04) else $error("count");
  AST_INT: assert property (rd_at(8'h05) |=> rd_data == {3'h0,
    $past(internal_comm_err, 2), $past(diag_buf_overflow, 2), 3'h0}) else $error("intdiag");
  AST_SUM: assert property (rd_at(8'h09) |=>
    rd_data == {4'h0, $past(any_ch, 2)}) else $error("summary");
  AST_CH0: assert property (rd_at(8'h0A) |=> rd_data == {$past(range_overflow[0], 2),
    $past(range_underflow[0], 2), 5'h0, $past(config_err[0], 2)}) else $error("chan0");
  AST_EVT: assert property (|(range_overflow & ~$past(range_overflow)) |=> diag_event)
    else $error("event");
  AST_TCK: assert property ($changed(us_ticks) |-> us_ticks == $past(us_ticks) + 32'h1)
    else $error("ticker");
endmodule // diag_record_sva
bind analog_input_diag_record diag_record_sva chk_u (.*);
`default_nettype wire

// ===== tb/tb.sv
// bench: record reads while errors change
// assumes diag_reader and bound checker
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [13:0] e       = 14'h0;
  logic [31:0] ts      = 32'h0;
  logic [7:0]  q[$];
  int          cyc, r, n_mismatch, n_checks;
  wire         rd_en, rd_valid, diag_event;
  wire  [7:0]  rd_index, rd_data;
  wire  [31:0] us_ticks;
  wire  [3:0]  config_err = e[13:10], range_underflow = e[9:6], range_overflow = e[5:2];
  wire         diag_buf_overflow = e[1], internal_comm_err = e[0];
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= rst_n ? cyc + 1 : 0;
  diag_reader rdr (.*);
  analog_input_diag_record dut_u (.*);
  task chk(input logic [31:0] g, x);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, g, x);
    end
  endtask
  task test_done;
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [7:0] ex(int i);
    case (i)
      3: return 8'h15;
      5: return {3'h0, e[0], e[1], 3'h0};
      6: return 8'h71;
      7: return 8'h08;
      8: return 8'h04;
      9: return {4'h0, e[13:10] | e[9:6] | e[5:2]};
      10, 11, 12, 13: return {e[i-8], e[i-4], 5'h0, e[i]};
      19, 20, 21, 22: return ts[8*(i-19) +: 8];
      default: return 8'h00;
    endcase
  endfunction
  task read_all;
    for (int i = 0; i < 24; i++) begin
      q.push_back(ex(i));
      rdr.rd(i[7:0], 1'b1);
    end
    rdr.rd(8'h00, 1'b0);
  endtask
  always @(posedge sys_clk) begin
    if (rst_n) chk(us_ticks, cyc > 0 ? (cyc - 1) / 50 : 0);
    if (rd_valid === 1'b1) chk(rd_data, q.pop_front());
  end
  initial begin
    r = $urandom(96);
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (40) begin
      read_all;
      r = $urandom;
      if (|(r[13:0] & ~e)) ts = cyc / 50;
      e <= r[13:0];
      repeat (2) rdr.rd(8'h00, 1'b0);
    end
    read_all;
    repeat (2) @(posedge sys_clk);
    test_done;
  end
  initial begin
    #200000;
    n_mismatch++;
    test_done;
  end
endmodule // tb
`default_nettype wire
